/* verilog/meas_seq_pkg.sv */
/*
 * Package for the measurement mode sequencer: register offsets, field
 * positions, reset values, timing constants and the mode state type.
 * Assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus.
 */
// Functional notes
// R01: Temperature and humidity resolution each 9/11/14 bits
// R02: Conversion length grows with configured resolution
// R03: Sleep after reset, no conversions until told
// R04: One measurement per host trigger command
// R05: Single shot returns to sleep by itself
// R06: Seven periodic rates, 2 minutes to 5/s
// R07: Continuous mode wakes, converts, sleeps unprompted
// R08: Reset sequence finishes within 3.5 ms
// R09: Heater switched on and off by software
// R10: Host keeps measuring while heater on
// R11: Store each result in its own register
// R12: Conversion done sets flag when enabled
// R13: No conversion before reset sequence completes
`default_nettype none
package meas_seq_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] STATUS_OFS   = 8'h04;
    localparam logic [7:0] IRQ_EN_OFS   = 8'h08;
    localparam logic [7:0] TEMP_OFS     = 8'h0c;
    localparam logic [7:0] HUM_OFS      = 8'h10;
    localparam logic [7:0] CONFIG_OFS   = 8'h14;
    // Control fields (trigger and soft reset are write-one pulses, heater is a level)
    localparam int TRIG_BIT     = 0;
    localparam int SOFT_RST_BIT = 1;
    localparam int HEATER_BIT   = 2;
    // Config fields
    localparam int RATE_LSB     = 0;   // 3 bits, 0 = single shot
    localparam int TRES_LSB     = 4;   // 2 bits
    localparam int HRES_LSB     = 6;   // 2 bits
    localparam int MEAS_LSB     = 8;   // 2 bits
    localparam logic [9:0] CONFIG_RESET = 10'h000;
    // Resolution codes
    localparam logic [1:0] RES_14 = 2'h0;
    localparam logic [1:0] RES_11 = 2'h1;
    localparam logic [1:0] RES_9  = 2'h2;
    // Measurement select
    localparam logic [1:0] MEAS_BOTH = 2'h0;
    localparam logic [1:0] MEAS_TEMP = 2'h1;
    // Status bits
    localparam int DONE_BIT  = 0;
    localparam int RESET_DONE_BIT = 1;
    localparam int STATUS_W  = 2;
    localparam logic [STATUS_W-1:0] STATUS_RESET = 2'h0;
    localparam int BUSY_BIT  = 8;   // read-only state bits
    localparam int HEAT_BIT  = 9;
    // Timing
    localparam int  CLK_HZ        = 20_000_000;
    localparam real RESET_TIME_MS = 3.5;
    localparam int  RESET_CYCLES  = int'(RESET_TIME_MS * CLK_HZ / 1000.0);
    localparam int  CONV_9_US     = 300;
    localparam int  CONV_11_US    = 400;
    localparam int  CONV_14_US    = 660;
    localparam int  CONV_9_CYC    = CONV_9_US * (CLK_HZ / 1_000_000);
    localparam int  CONV_11_CYC   = CONV_11_US * (CLK_HZ / 1_000_000);
    localparam int  CONV_14_CYC   = CONV_14_US * (CLK_HZ / 1_000_000);
    // Periodic intervals in ms for rate codes 1..7
    localparam int  PER_1_MS = 120_000;
    localparam int  PER_2_MS = 60_000;
    localparam int  PER_3_MS = 10_000;
    localparam int  PER_4_MS = 5_000;
    localparam int  PER_5_MS = 1_000;
    localparam int  PER_6_MS = 500;
    localparam int  PER_7_MS = 200;
    localparam int  CYC_PER_MS = CLK_HZ / 1000;
    localparam int  TICK_MS_CYCLES = CYC_PER_MS;
    typedef enum logic [2:0] {
        ST_RESET, ST_SLEEP, ST_TEMP, ST_HUM, ST_STORE
    } seq_state_e;
endpackage
`default_nettype wire

/* verilog/conv_timer.sv */
/*
 * Down counter that times one conversion. Loaded with a cycle count,
 * pulses done when it reaches the end. Same clock as the sequencer.
 */
`default_nettype none
module conv_timer
    import meas_seq_pkg::*;
#(
    parameter int WIDTH = 24
)(
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             clkEn,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadValue,
    output logic                  done
);
    logic [WIDTH-1:0] count_reg;
    logic             run_reg;

    initial
    begin
        if (WIDTH < 2)
            $error("conv_timer WIDTH too small");
    end

    // Reload wins over a running count
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            count_reg <= '0;
            run_reg   <= 1'b0;
        end
        else if (clkEn)
        begin
            if (load)
            begin
                count_reg <= loadValue;
                run_reg   <= 1'b1;
            end
            else if (run_reg)
            begin
                count_reg <= count_reg - 1'b1;
                if (count_reg <= 1)
                    run_reg <= 1'b0;
            end
        end
    end

    assign done = clkEn & run_reg & (count_reg <= 1); // Load may come in the same cycle as done
endmodule
`default_nettype wire

/* verilog/meas_sequencer.sv */
/*
 * Measurement mode sequencer: sleep, single-shot and periodic
 * conversions, selectable resolution, heater control, reset sequence,
 * result registers and a sticky done interrupt, all behind AHB-Lite.
 * Assumes a sampled sensor value on plain inputs and a link clock pin
 * from the host side that only flags trigger commands.
 */
`default_nettype none
module meas_sequencer
    import meas_seq_pkg::*;
#(
    parameter int RESET_CYC = RESET_CYCLES,
    parameter int MS_CYC    = TICK_MS_CYCLES
)(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Serial-side trigger command and its link clock
    input  wire logic        linkClk,
    input  wire logic        linkTrig,
    // Sensor front end samples
    input  wire logic [15:0] tempSample,
    input  wire logic [15:0] humSample,
    // Device outputs
    output logic             heaterOn,
    output logic             irq
);
    // Counters below are sized for the documented defaults
    initial
    begin
        if (RESET_CYC < 1 || MS_CYC < 1)
            $error("meas_sequencer counts must be positive");
        if (RESET_CYC > (1 << 23) || MS_CYC > (1 << 16))
            $error("meas_sequencer counts too wide for counters");
    end

    // Bus address phase capture
    logic       wrPend_reg;
    logic       rdPend_reg;
    logic [7:0] addr_reg;
    wire  logic addrPhase = hsel & htrans[1] & hready;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wrPend_reg <= 1'b0;
            rdPend_reg <= 1'b0;
            addr_reg   <= 8'h00;
        end
        else if (clkEn)
        begin
            wrPend_reg <= addrPhase & hwrite;
            rdPend_reg <= addrPhase & ~hwrite;
            if (addrPhase)
                addr_reg <= haddr;
        end
    end

    assign hreadyout = 1'b1;   // Zero wait states
    assign hresp     = 1'b0;   // Always OKAY

    // Write decodes
    wire logic wrCtrl   = wrPend_reg & (addr_reg == CTRL_OFS);
    wire logic wrStatus = wrPend_reg & (addr_reg == STATUS_OFS);
    wire logic wrIrqEn  = wrPend_reg & (addr_reg == IRQ_EN_OFS);
    wire logic wrConfig = wrPend_reg & (addr_reg == CONFIG_OFS);
    wire logic swTrig   = wrCtrl & hwdata[TRIG_BIT];
    wire logic swReset  = wrCtrl & hwdata[SOFT_RST_BIT];

    // Link pins: two flops each, then edge finding on the safe copy
    logic [1:0] linkClkSync_reg;
    logic [1:0] linkTrigSync_reg;
    logic       linkClkLast_reg;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            linkClkSync_reg  <= 2'b00;
            linkTrigSync_reg <= 2'b00;
            linkClkLast_reg  <= 1'b0;
        end
        else if (clkEn)
        begin
            linkClkSync_reg  <= {linkClkSync_reg[0], linkClk};
            linkTrigSync_reg <= {linkTrigSync_reg[0], linkTrig};
            linkClkLast_reg  <= linkClkSync_reg[1];
        end
    end

    // Trigger bit sampled at a rising link clock edge
    wire logic linkRise = linkClkSync_reg[1] & ~linkClkLast_reg;
    wire logic linkCmd  = linkRise & linkTrigSync_reg[1];
    wire logic trigCmd  = swTrig | linkCmd;

    // Configuration register
    logic [9:0] config_reg;
    logic       heater_reg;
    logic [STATUS_W-1:0] irqEn_reg;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            config_reg <= CONFIG_RESET;
            heater_reg <= 1'b0;
            irqEn_reg  <= '0;
        end
        else if (clkEn)
        begin
            if (wrConfig)
                config_reg <= hwdata[9:0];
            if (wrCtrl)
                heater_reg <= hwdata[HEATER_BIT];  // R09
            if (wrIrqEn)
                irqEn_reg <= hwdata[STATUS_W-1:0];
        end
    end

    assign heaterOn = heater_reg;

    wire logic [2:0] rateSel = config_reg[RATE_LSB +: 3];
    wire logic [1:0] tempRes = config_reg[TRES_LSB +: 2];
    wire logic [1:0] humRes  = config_reg[HRES_LSB +: 2];
    wire logic [1:0] measSel = config_reg[MEAS_LSB +: 2];

    // Resolution to conversion cycles; longer for more bits
    function automatic logic [23:0] convCycles(input logic [1:0] res);
        logic [23:0] c;
        c = 24'(CONV_14_CYC);
        case (res)
            RES_9:   c = 24'(CONV_9_CYC);   // R01 R02
            RES_11:  c = 24'(CONV_11_CYC);  // R01 R02
            default: c = 24'(CONV_14_CYC);  // R01 R02
        endcase
        return c;
    endfunction

    // Sampling interval in ms for codes 1..7; 0 means single shot
    function automatic logic [16:0] periodMs(input logic [2:0] code);
        logic [16:0] p;
        p = 17'(PER_1_MS);
        case (code)
            3'h1:    p = 17'(PER_1_MS);   // R06
            3'h2:    p = 17'(PER_2_MS);
            3'h3:    p = 17'(PER_3_MS);
            3'h4:    p = 17'(PER_4_MS);
            3'h5:    p = 17'(PER_5_MS);
            3'h6:    p = 17'(PER_6_MS);
            3'h7:    p = 17'(PER_7_MS);   // R06
            default: p = 17'(PER_1_MS);
        endcase
        return p;
    endfunction

    // Sequencer state
    seq_state_e state_reg;
    seq_state_e state_next;
    logic [22:0] rstCnt_reg;
    logic [15:0] msCnt_reg;
    logic [16:0] perCnt_reg;
    logic [15:0] temp_reg;
    logic [15:0] hum_reg;
    logic [STATUS_W-1:0] status_reg;
    logic        timerLoad;
    logic [23:0] timerValue;
    logic        convDone;

    conv_timer #(
        .WIDTH     (24)
    ) u_timer (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .clkEn     (clkEn),
        .load      (timerLoad),
        .loadValue (timerValue),
        .done      (convDone)
    );

    wire logic periodic  = (rateSel != 3'h0);
    wire logic rstOver   = (rstCnt_reg == 23'(RESET_CYC - 1));
    wire logic msTick    = (msCnt_reg == 16'(MS_CYC - 1));
    wire logic perExpire = periodic & msTick & (perCnt_reg <= 17'h1);
    // Trigger only honoured in single-shot mode while asleep
    wire logic startConv = (state_reg == ST_SLEEP) &
                           ((~periodic & trigCmd) | perExpire);

    // Next-state and timer load selection
    always_comb
    begin
        state_next = state_reg;
        timerLoad  = 1'b0;
        timerValue = convCycles(tempRes);
        case (state_reg)
            ST_RESET:
                if (rstOver)
                    state_next = ST_SLEEP;          // R03 R08 R13
            ST_SLEEP:
                if (startConv)                      // R04 R07
                begin
                    state_next = ST_TEMP;
                    timerLoad  = 1'b1;
                end
            ST_TEMP:
                if (convDone)
                begin
                    if (measSel == MEAS_TEMP)
                        state_next = ST_STORE;
                    else
                    begin
                        state_next = ST_HUM;
                        timerLoad  = 1'b1;
                        timerValue = convCycles(humRes);  // R02
                    end
                end
            ST_HUM:
                if (convDone)
                    state_next = ST_STORE;
            ST_STORE:
                state_next = ST_SLEEP;              // R05 R07
            default:
                state_next = ST_RESET;
        endcase
    end

    // State and reset counter
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg  <= ST_RESET;                 // R03
            rstCnt_reg <= '0;
        end
        else if (clkEn)
        begin
            if (swReset)
            begin
                state_reg  <= ST_RESET;             // R08
                rstCnt_reg <= '0;
            end
            else
            begin
                state_reg <= state_next;
                if (state_reg == ST_RESET)
                    rstCnt_reg <= rstCnt_reg + 1'b1;
            end
        end
    end

    // Interval restarts on a config write, so a new rate counts
    // its own full period rather than what was left of the old one
    wire logic [2:0] newRate = hwdata[RATE_LSB +: 3];
    wire logic       perLast = (perCnt_reg <= 17'h1);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            msCnt_reg  <= '0;
            perCnt_reg <= '0;
        end
        else if (clkEn)
        begin
            msCnt_reg <= msTick ? 16'h0 : msCnt_reg + 1'b1;
            if (wrConfig)
                perCnt_reg <= periodMs(newRate);        // R06
            else if (!periodic || (state_reg == ST_RESET))
                perCnt_reg <= periodMs(rateSel);
            else if (msTick)
                perCnt_reg <= perLast ? periodMs(rateSel) :
                                        perCnt_reg - 1'b1;  // R07
        end
    end

    // Results and sticky status; set wins over write-one clear
    wire logic doneEvt = (state_reg == ST_STORE);
    wire logic rstEvt  = (state_reg == ST_RESET) & rstOver & ~swReset;
    logic [STATUS_W-1:0] setBits;
    assign setBits[DONE_BIT]       = doneEvt & irqEn_reg[DONE_BIT]; // R12
    assign setBits[RESET_DONE_BIT] = rstEvt & irqEn_reg[RESET_DONE_BIT];
    wire logic [STATUS_W-1:0] clrBits =
        wrStatus ? hwdata[STATUS_W-1:0] : '0;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            temp_reg   <= 16'h0000;
            hum_reg    <= 16'h0000;
            status_reg <= STATUS_RESET;
        end
        else if (clkEn)
        begin
            if (state_reg == ST_TEMP && convDone)
                temp_reg <= tempSample;             // R11
            if (state_reg == ST_HUM && convDone)
                hum_reg <= humSample;               // R11
            status_reg <= (status_reg & ~clrBits) | setBits;  // R12
        end
    end

    // Mask is the enable register itself
    assign irq = |(status_reg & irqEn_reg);

    // Read mux, registered for the data phase
    wire logic busy = (state_reg != ST_SLEEP);
    // Live state bits sit above the sticky flags
    wire logic [31:0] statusWord = {22'h0, heater_reg, busy, 6'h0,
                                    status_reg};
    logic [31:0] readMux;
    always_comb
    begin
        case (haddr)
            CTRL_OFS:   readMux = {29'h0, heater_reg, 2'h0};
            STATUS_OFS: readMux = statusWord;
            IRQ_EN_OFS: readMux = {30'h0, irqEn_reg};
            TEMP_OFS:   readMux = {16'h0, temp_reg};
            HUM_OFS:    readMux = {16'h0, hum_reg};
            CONFIG_OFS: readMux = {22'h0, config_reg};
            default:    readMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            hrdata <= 32'h0000_0000;
        else if (clkEn && addrPhase && !hwrite)
            hrdata <= readMux;
    end
endmodule
`default_nettype wire

/* test/meas_seq_monitor.sv */
/*
 * Checker on the sequencer's top ports: bus answer, heater, interrupt.
 * Assumes transfers spaced by an idle cycle and clkEn held high.
 */
`default_nettype none
module meas_seq_monitor
    import meas_seq_pkg::*;
#(
    parameter int RESET_CYC = RESET_CYCLES,
    parameter int MS_CYC    = TICK_MS_CYCLES
)(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        heaterOn,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic    dWr, dCtrlWr, dIrqEnWr, dUnmRd, wrHeat;
    wire logic take  = hsel && htrans[1] && hready;
    wire logic takeW = take && hwrite;
    wire logic takeR = take && !hwrite;
    // Data-phase markers, one cycle behind the address phase
    always_ff @(posedge clk)
    begin
        dWr      <= !sys_rst && takeW;
        dCtrlWr  <= !sys_rst && takeW && haddr == CTRL_OFS;
        dIrqEnWr <= !sys_rst && takeW && haddr == IRQ_EN_OFS;
        dUnmRd   <= !sys_rst && take && !hwrite && haddr > CONFIG_OFS;
        if (dCtrlWr)
            wrHeat <= hwdata[HEATER_BIT];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_reset_quiet: assert property ($fell(sys_rst) |->
        !irq && !heaterOn && hrdata == 32'h0)
        else $error("outputs not quiet after reset");
    a_heater_write: assert property (dCtrlWr |=> ##[0:1] heaterOn == wrHeat)
        else $error("heater does not follow control write");
    a_heater_hold: assert property ($changed(heaterOn) |-> $past(dCtrlWr)
        || $past(dCtrlWr, 2) || $past(sys_rst) || $past(sys_rst, 2))
        else $error("heater changed without control write");
    a_mask_irq: assert property (dIrqEnWr && hwdata[1:0] == 2'h0
        |-> ##[1:2] !irq)
        else $error("interrupt high while all masked");
    a_irq_sticky: assert property ($fell(irq) |-> $past(dWr)
        || $past(dWr, 2) || $past(sys_rst) || $past(sys_rst, 2))
        else $error("interrupt dropped without a write");
    a_unmapped_zero: assert property (dUnmRd |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property ($changed(hrdata) |->
        $past(takeR) || $past(sys_rst))
        else $error("read data changed without a read");
endmodule
bind meas_sequencer meas_seq_monitor #(.RESET_CYC(RESET_CYC),
    .MS_CYC(MS_CYC)) i_meas_seq_monitor (.clk(clk), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .heaterOn(heaterOn), .irq(irq));
`default_nettype wire

/* test/host_link_model.sv */
/*
 * Host side of the trigger link: link clock only within a frame.
 * Assumes the sequencer samples both pins with its own clock.
 */
`default_nettype none
module host_link_model (
    output logic linkClk,
    output logic linkTrig
);
    timeunit 1ns;
    timeprecision 100ps;
    // Clock stands low between frames
    initial
    begin
        linkClk  = 1'b0;
        linkTrig = 1'b0;
    end
    // Two edges per frame: the second lands while busy, must be ignored
    task automatic send_trig();
        #37 linkTrig = 1'b1;
        repeat (2)
        begin
            #200 linkClk = 1'b1;
            #200 linkClk = 1'b0;
        end
        #200 linkTrig = 1'b0;
    endtask
endmodule
`default_nettype wire

/* test/meas_sequencer_tb.sv */
/*
 * Self-checking bench for the sequencer over AHB-Lite and the link.
 * Assumes the monitor is bound in and short reset and ms counts.
 */
`default_nettype none
module meas_sequencer_tb
    import meas_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int RC = 50;
    localparam logic [31:0] T9 = 32'h1a0; // Temp only, 9 bit
    logic        clk, sys_rst, hsel, hwrite, hreadyout, hresp;
    logic        heaterOn, irq, linkClk, linkTrig;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [15:0] tempSample, humSample;
    int          num_errors = 0, samples_checked = 0, n, nBoth;

    meas_sequencer #(.RESET_CYC(RC), .MS_CYC(4)) i_meas_sequencer (
        .clk(clk), .sys_rst(sys_rst), .clkEn(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .linkClk(linkClk),
        .linkTrig(linkTrig), .tempSample(tempSample),
        .humSample(humSample), .heaterOn(heaterOn), .irq(irq));
    host_link_model i_host_link_model (.linkClk(linkClk),
        .linkTrig(linkTrig));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One single word transfer; waits on hready in both phases
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic settle(input int c);
        repeat (c) @(negedge clk);
    endtask
    // Cycles from trigger write to interrupt; watchdog bounds it
    task automatic conv(input logic [31:0] cfg);
        bus(1'b1, CONFIG_OFS, cfg);
        bus(1'b1, STATUS_OFS, 32'h3);
        bus(1'b1, CTRL_OFS, 32'h1);
        n = 0;
        while (irq !== 1'b1)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic t_reset();
        bus(1'b1, CTRL_OFS, 32'h1); // Trigger inside reset sequence
        rdchk(STATUS_OFS, 32'h100);
        rdchk(CONFIG_OFS, 32'(CONFIG_RESET));
        rdchk(IRQ_EN_OFS, 32'h0);
        settle(RC + 20);
        rdchk(STATUS_OFS, 32'h0);
        bus(1'b1, 8'h20, 32'hffff_ffff);
        rdchk(8'h20, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_single();
        tempSample <= 16'h1234;
        humSample <= 16'habcd;
        bus(1'b1, IRQ_EN_OFS, 32'h1);
        conv(32'h0a0);
        nBoth = n;
        rdchk(TEMP_OFS, 32'h1234);
        rdchk(HUM_OFS, 32'habcd);
        settle(1000);
        rdchk(STATUS_OFS, 32'h1);
        bus(1'b1, IRQ_EN_OFS, 32'h0);
        settle(2);
        chk(irq, 1'b0);
        rdchk(STATUS_OFS, 32'h1);
        bus(1'b1, IRQ_EN_OFS, 32'h1);
        settle(2);
        chk(irq, 1'b1);
        bus(1'b1, STATUS_OFS, 32'h1);
        settle(2);
        chk(irq, 1'b0);
        $display("test single done");
    endtask
    task automatic t_res();
        logic [1:0] code [3] = '{RES_9, RES_11, RES_14};
        int         cyc [3] = '{CONV_9_CYC, CONV_11_CYC, CONV_14_CYC};
        int         base;
        for (int i = 0; i < 3; i++)
        begin
            conv(32'h100 | 32'(code[i]) << TRES_LSB);
            if (i == 0)
                base = n;
            chk(32'(n - base), 32'(cyc[i] - cyc[0]));
        end
        conv(32'h020 | 32'(RES_14) << HRES_LSB);
        chk(32'(n - nBoth), 32'(CONV_14_CYC - CONV_9_CYC));
        $display("test resolution done");
    endtask
    task automatic t_link();
        bus(1'b1, CTRL_OFS, 32'h4);
        settle(2);
        chk(heaterOn, 1'b1);
        bus(1'b1, CONFIG_OFS, T9);
        bus(1'b1, STATUS_OFS, 32'h1);
        tempSample <= 16'h0042;
        i_host_link_model.send_trig();
        while (irq !== 1'b1) @(negedge clk);
        settle(100);
        rdchk(TEMP_OFS, 32'h42);
        rdchk(STATUS_OFS, 32'h201);
        bus(1'b1, STATUS_OFS, 32'h1);
        bus(1'b1, CTRL_OFS, 32'h0);
        settle(2);
        chk(heaterOn, 1'b0);
        $display("test link done");
    endtask
    task automatic t_periodic();
        for (int r = 1; r < 8; r++)
        begin
            bus(1'b1, CONFIG_OFS, 32'(r));
            rdchk(CONFIG_OFS, 32'(r));
        end
        bus(1'b1, CONFIG_OFS, 32'h0);
        bus(1'b1, STATUS_OFS, 32'h1);
        bus(1'b1, CONFIG_OFS, T9 | 32'h7);
        n = 0;
        while (irq !== 1'b1)
        begin
            @(negedge clk);
            n++;
        end
        chk(n >= CONV_9_CYC && n <= CONV_9_CYC + 850, 1'b1);
        bus(1'b1, CONFIG_OFS, T9);
        settle(CONV_9_CYC + 900);
        bus(1'b1, STATUS_OFS, 32'h1);
        settle(1000);
        chk(irq, 1'b0);
        $display("test periodic done");
    endtask
    task automatic t_softrst();
        bus(1'b1, IRQ_EN_OFS, 32'h3);
        bus(1'b1, CTRL_OFS, 32'h2);
        bus(1'b1, CTRL_OFS, 32'h1);
        settle(10);
        rdchk(STATUS_OFS, 32'h100);
        settle(RC);
        rdchk(STATUS_OFS, 32'h2);
        bus(1'b1, CONFIG_OFS, T9);
        bus(1'b1, CTRL_OFS, 32'h1);
        settle(10);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk(rd[BUSY_BIT], 1'b1);
        $display("test soft reset done");
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog above the expected run of about 81k cycles
    initial
    begin
        repeat (100000) @(posedge clk);
        num_errors++;
        $display("watchdog expired at %0t", $time);
        finish_test();
    end
    initial
    begin
        {hsel, hwrite, haddr, htrans, hwdata} = '0;
        {tempSample, humSample} = '0;
        hsize = 3'h2;
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_single();
        t_res();
        t_link();
        t_periodic();
        t_softrst();
        finish_test();
    end
endmodule
`default_nettype wire
